// ### core/port_b_alt_function_mux.sv
// Purpose: per-pin override of port b bits 7..1 by alternate functions
// Assumes: all inputs synchronous to clock
// Notes: bit 0 outputs held at reset value; one cycle registered latency
`timescale 1ns/1ns
`include "port_b_mux_regs.svh"
`default_nettype none
module port_b_alt_function_mux
	import port_b_mux_pkg::*;
#(
	parameter int PIN_COUNT = `PIN_COUNT
)
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic [7:0]  direction_reg,
	input  wire logic [7:0]  out_latch,
	input  wire logic [7:0]  pin_in,
	input  wire logic        global_irq_enable,
	input  wire logic        pin_change_irq_group_high,
	input  wire logic        pin_change_irq_group_low,
	input  wire logic        reset_pin_disable_fuse,
	input  wire logic        external_irq_zero,
	input  wire logic        ext_irq_low_level,
	input  wire logic        clock_select_bit2,
	input  wire logic        clock_select_bit1,
	input  wire clk_src_t    clock_source,
	input  wire usi_mode_t   usi_mode,
	input  wire logic        spi_prog_enable,
	input  wire logic        usi_start_detect,
	input  wire logic        usi_data_out,
	input  wire logic        compare_a_output,
	input  wire logic        compare_a_enable,
	input  wire logic        compare_b_output,
	input  wire logic        compare_b_enable,
	input  wire logic        compare_b_inv_enable,
	input  wire logic        sleep_mode,
	output logic [7:0]       pad_out_ff,
	output logic [7:0]       pad_oe_ff,
	output logic [7:0]       pull_up_ff,
	output logic [7:0]       din_enable_ff,
	output logic [7:0]       pin_change_en_ff,
	output logic             ext_reset_n_ff,
	output logic             ext_irq_zero_in_ff,
	output logic             counter_zero_ext_clock_pin_ff,
	output logic             osc_input_pin_ff
);
	logic [7:0] nxt_pad_out;
	logic [7:0] nxt_pad_oe;
	logic [7:0] nxt_pull_up;
	logic [7:0] nxt_din_enable;
	logic [7:0] nxt_pin_change_en;
	logic [7:0] alt_mask;
	logic [7:0] grp_en;
	logic       nxt_ext_reset_n;
	logic       nxt_ext_irq;
	logic       nxt_cnt_clk;
	logic       nxt_osc_in;
	logic       reset_use;
	logic       cnt_clk_use;
	logic       osc_out_use;
	logic       osc_in_use;
	logic       usi_on;
	logic       sclk_use;
	logic       sdata_use;

	// the override map is wired for exactly one eight-bit port
	if (PIN_COUNT != 8) begin : g_bad_width
		$error("port width must be eight");
	end

	always_comb begin
		reset_use   = reset_pin_disable_fuse == `FUSE_RESET_ON;
		cnt_clk_use = clock_select_bit2 & clock_select_bit1;
		osc_out_use = clock_source == CLK_CRYSTAL;
		osc_in_use  = (clock_source == CLK_CRYSTAL)
			| (clock_source == CLK_EXTERNAL);
		usi_on      = (usi_mode == USI_THREE) | (usi_mode == USI_TWO);
		sclk_use    = usi_on | spi_prog_enable;
		sdata_use   = (usi_mode == USI_THREE) & direction_reg[`BIT_SDATA];
		alt_mask = 8'h00;
		alt_mask[`BIT_RESET]   = reset_use;
		alt_mask[`BIT_EXT_IRQ] = (external_irq_zero & ext_irq_low_level)
			| cnt_clk_use;
		alt_mask[`BIT_OSC_OUT] = osc_out_use;
		alt_mask[`BIT_OSC_IN]  = osc_in_use;
		alt_mask[`BIT_CMP_B]   = compare_b_enable;
		alt_mask[`BIT_SCLK]    = compare_b_inv_enable | sclk_use;
		alt_mask[`BIT_SDATA]   = compare_a_enable | sdata_use;
		grp_en = {{4{pin_change_irq_group_high}},
			{4{pin_change_irq_group_low}}};
		// output direction deliberately ignored here
		nxt_pin_change_en = {8{global_irq_enable}} & grp_en
			& ~alt_mask;
		nxt_pin_change_en[0] = 1'b0;
		nxt_pad_out    = out_latch;
		nxt_pad_oe     = direction_reg;
		nxt_pull_up    = out_latch & ~direction_reg;
		nxt_din_enable = sleep_mode ? nxt_pin_change_en : 8'hff;
		if (reset_use) begin
			nxt_pad_oe[`BIT_RESET]     = 1'b0;
			nxt_pull_up[`BIT_RESET]    = 1'b1;
			nxt_din_enable[`BIT_RESET] = 1'b0;
		end
		if (osc_out_use) begin
			nxt_pad_oe[`BIT_OSC_OUT]  = 1'b0;
			nxt_pull_up[`BIT_OSC_OUT] = 1'b0;
		end
		if (osc_in_use) begin
			nxt_pad_oe[`BIT_OSC_IN]  = 1'b0;
			nxt_pull_up[`BIT_OSC_IN] = 1'b0;
		end
		if (compare_b_enable & direction_reg[`BIT_CMP_B])
			nxt_pad_out[`BIT_CMP_B] = compare_b_output;
		if (spi_prog_enable) begin
			nxt_pad_oe[`BIT_SCLK] = 1'b0;
		end else if (usi_mode == USI_TWO) begin
			// open drain: drive only the low level
			nxt_pad_out[`BIT_SCLK] = 1'b0;
			nxt_pad_oe[`BIT_SCLK]  = direction_reg[`BIT_SCLK]
				& (~out_latch[`BIT_SCLK] | usi_start_detect);
			nxt_pull_up[`BIT_SCLK] = 1'b0;
		end else if (usi_mode == USI_THREE) begin
			nxt_pad_oe[`BIT_SCLK] = direction_reg[`BIT_SCLK];
		end else if (compare_b_inv_enable & direction_reg[`BIT_SCLK]) begin
			nxt_pad_out[`BIT_SCLK] = ~compare_b_output;
		end
		if (sdata_use)
			nxt_pad_out[`BIT_SDATA] = usi_data_out;
		else if (compare_a_enable & direction_reg[`BIT_SDATA]
			& ~usi_on & ~spi_prog_enable)
			nxt_pad_out[`BIT_SDATA] = compare_a_output;
		nxt_pad_out[0]    = 1'b0;
		nxt_pad_oe[0]     = 1'b0;
		nxt_pull_up[0]    = 1'b0;
		nxt_din_enable[0] = 1'b0;
		nxt_ext_reset_n = reset_use ? pin_in[`BIT_RESET] : 1'b1;
		nxt_ext_irq = external_irq_zero & pin_in[`BIT_EXT_IRQ];
		nxt_cnt_clk = cnt_clk_use & pin_in[`BIT_EXT_IRQ];
		nxt_osc_in  = osc_in_use & pin_in[`BIT_OSC_IN];
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pad_out_ff                    <= `OUT_RESET;
			pad_oe_ff                     <= `OUT_RESET;
			pull_up_ff                    <= `OUT_RESET;
			din_enable_ff                 <= `OUT_RESET;
			pin_change_en_ff              <= `OUT_RESET;
			ext_reset_n_ff                <= 1'b1;
			ext_irq_zero_in_ff            <= 1'b0;
			counter_zero_ext_clock_pin_ff <= 1'b0;
			osc_input_pin_ff              <= 1'b0;
		end else begin
			pad_out_ff                    <= nxt_pad_out;
			pad_oe_ff                     <= nxt_pad_oe;
			pull_up_ff                    <= nxt_pull_up;
			din_enable_ff                 <= nxt_din_enable;
			pin_change_en_ff              <= nxt_pin_change_en;
			ext_reset_n_ff                <= nxt_ext_reset_n;
			ext_irq_zero_in_ff            <= nxt_ext_irq;
			counter_zero_ext_clock_pin_ff <= nxt_cnt_clk;
			osc_input_pin_ff              <= nxt_osc_in;
		end
	end

	// checkers share one clock and the synchronous reset
	default clocking cb_main @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence s_scl_pull_req;
		usi_mode == USI_TWO && !spi_prog_enable && direction_reg[2]
			&& (!out_latch[2] || usi_start_detect);
	endsequence

	sequence s_scl_line_low;
		pad_oe_ff[2] && !pad_out_ff[2] && !pull_up_ff[2];
	endsequence

	sequence s_sdata_req;
		usi_mode == USI_THREE && direction_reg[1];
	endsequence

	a_reset_pin_role: assert property (
		reset_pin_disable_fuse
		|=> pull_up_ff[7] && !pad_oe_ff[7] && !din_enable_ff[7])
		else $error("bit 7 not serving as reset");

	a_reset_level: assert property (
		reset_pin_disable_fuse |=> ext_reset_n_ff == $past(pin_in[7]))
		else $error("reset input does not follow bit 7");

	a_reset_mask: assert property (
		reset_pin_disable_fuse |=> !pin_change_en_ff[7])
		else $error("bit 7 pin change not masked by reset use");

	a_pc_needs_global: assert property (
		!global_irq_enable |=> pin_change_en_ff == 8'h00)
		else $error("pin change enabled without global enable");

	a_pc_group_low: assert property (
		!pin_change_irq_group_low |=> pin_change_en_ff[3:0] == 4'h0)
		else $error("low group enabled without its enable");

	a_pc_on_output: assert property (
		global_irq_enable && pin_change_irq_group_low
		&& !compare_b_enable && direction_reg[3]
		|=> pin_change_en_ff[3])
		else $error("pin change lost on an output pin");

	a_ext_irq_route: assert property (
		external_irq_zero |=> ext_irq_zero_in_ff == $past(pin_in[6]))
		else $error("bit 6 not routed to external irq");

	a_ext_irq_off: assert property (
		!external_irq_zero |=> !ext_irq_zero_in_ff)
		else $error("external irq input active while disabled");

	a_cnt_clk_route: assert property (
		clock_select_bit2 && clock_select_bit1
		|=> counter_zero_ext_clock_pin_ff == $past(pin_in[6]))
		else $error("bit 6 not routed to counter clock");

	a_cnt_clk_off: assert property (
		!(clock_select_bit2 && clock_select_bit1)
		|=> !counter_zero_ext_clock_pin_ff)
		else $error("counter clock input active while unselected");

	a_cnt_clk_mask: assert property (
		clock_select_bit2 && clock_select_bit1 |=> !pin_change_en_ff[6])
		else $error("bit 6 pin change not masked by counter clock");

	a_level_irq_mask: assert property (
		external_irq_zero && ext_irq_low_level |=> !pin_change_en_ff[6])
		else $error("bit 6 pin change not masked by level irq");

	a_osc_out_role: assert property (
		clock_source != CLK_CRYSTAL
		|=> pad_oe_ff[5] == $past(direction_reg[5]))
		else $error("bit 5 not ordinary io");

	a_osc_out_noio: assert property (
		clock_source == CLK_CRYSTAL
		|=> !pad_oe_ff[5] && !pin_change_en_ff[5])
		else $error("bit 5 used as io while oscillator output");

	a_osc_in_role: assert property (
		clock_source == CLK_CRYSTAL || clock_source == CLK_EXTERNAL
		|=> !pad_oe_ff[4] && osc_input_pin_ff == $past(pin_in[4]))
		else $error("bit 4 not serving as oscillator input");

	a_osc_in_mask: assert property (
		clock_source == CLK_EXTERNAL
		|=> !pin_change_en_ff[4]
		&& pad_oe_ff[5] == $past(direction_reg[5]))
		else $error("bit 4 or 5 wrong for external clock");

	a_cmp_b_drive: assert property (
		compare_b_enable && direction_reg[3]
		|=> pad_out_ff[3] == $past(compare_b_output))
		else $error("compare b not driven on bit 3");

	a_cmp_b_mask: assert property (
		compare_b_enable |=> !pin_change_en_ff[3])
		else $error("bit 3 pin change not masked by compare b");

	a_sclk_spi_in: assert property (
		spi_prog_enable |=> !pad_oe_ff[2])
		else $error("bit 2 driven while programming");

	a_sclk_three: assert property (
		usi_mode == USI_THREE && !spi_prog_enable
		|=> pad_oe_ff[2] == $past(direction_reg[2]))
		else $error("bit 2 direction wrong in three-wire mode");

	a_scl_pull_low: assert property (
		s_scl_pull_req |=> s_scl_line_low)
		else $error("clock line not pulled low");

	a_inv_cmp_b: assert property (
		usi_mode != USI_THREE && usi_mode != USI_TWO
		&& !spi_prog_enable && compare_b_inv_enable && direction_reg[2]
		|=> pad_out_ff[2] == !$past(compare_b_output))
		else $error("inverted compare b not driven on bit 2");

	a_sclk_mask: assert property (
		compare_b_inv_enable || usi_mode == USI_THREE
		|| usi_mode == USI_TWO
		|=> !pin_change_en_ff[2])
		else $error("bit 2 pin change not masked");

	a_sdata_drive: assert property (
		s_sdata_req
		|=> pad_out_ff[1] == $past(usi_data_out) && !pin_change_en_ff[1])
		else $error("serial data not driven on bit 1");

	a_sdata_pull: assert property (
		usi_mode == USI_THREE && !direction_reg[1]
		|=> pull_up_ff[1] == $past(out_latch[1]))
		else $error("bit 1 pull-up not from latch");

	a_cmp_a_drive: assert property (
		compare_a_enable && direction_reg[1] && !spi_prog_enable
		&& usi_mode != USI_THREE && usi_mode != USI_TWO
		|=> pad_out_ff[1] == $past(compare_a_output))
		else $error("compare a not driven on bit 1");

	a_cmp_a_mask: assert property (
		compare_a_enable |=> !pin_change_en_ff[1])
		else $error("bit 1 pin change not masked by compare a");

	a_sleep_din: assert property (
		sleep_mode |=> din_enable_ff == pin_change_en_ff)
		else $error("sleep input enable differs from pin change enable");

	a_awake_din: assert property (
		!sleep_mode && !reset_pin_disable_fuse |=> din_enable_ff == 8'hfe)
		else $error("input buffer off while awake");

	// bit 0 lies outside this block and must stay quiet
	a_bit0_idle: assert property (
		1'b1 |=> {pad_out_ff[0], pad_oe_ff[0], pull_up_ff[0],
		pin_change_en_ff[0]} == 4'h0)
		else $error("bit 0 not idle");
endmodule : port_b_alt_function_mux
`default_nettype wire

// ### core/port_b_mux_pkg.sv
// Purpose: types for the port b alternate-function override logic
// Assumes: none
// Notes: encodings are local choices
package port_b_mux_pkg;
	typedef enum logic [1:0] {
		USI_OFF       = 2'b00,
		USI_THREE     = 2'b01,
		USI_TWO       = 2'b10,
		USI_RSVD      = 2'b11
	} usi_mode_t;
	typedef enum logic [1:0] {
		CLK_CRYSTAL   = 2'b00,
		CLK_RC        = 2'b01,
		CLK_EXTERNAL  = 2'b10,
		CLK_PLL       = 2'b11
	} clk_src_t;
endpackage : port_b_mux_pkg

// ### core/port_b_mux_regs.svh
// Purpose: constants for the port b alternate-function override logic
// Assumes: pin bits 7..1 handled, bit 0 outside this block
// Notes: usi mode and clock source encodings are local choices
`ifndef PORT_B_MUX_REGS_SVH
`define PORT_B_MUX_REGS_SVH
`define PIN_COUNT     8
`define BIT_RESET     7
`define BIT_EXT_IRQ   6
`define BIT_OSC_OUT   5
`define BIT_OSC_IN    4
`define BIT_CMP_B     3
`define BIT_SCLK      2
`define BIT_SDATA     1
`define FUSE_RESET_ON 1'b1
`define OUT_RESET     8'h00
`endif

// ### sim/test_port_b_alt_function_mux.sv
// Purpose: bench for the port b alternate-function mux
// Assumes: outputs lag inputs by one edge
// Notes: two edges per step, since the partner adds one more
`timescale 1ns/1ns
`default_nettype none
module test_port_b_alt_function_mux
	import port_b_mux_pkg::*;
;
	logic       clock, reset_n, gie, grp_hi, grp_lo, fuse, irq0, low_lvl;
	logic       cs2, cs1, spi, start, ca_en, cb_en, cbi_en, sleep;
	logic       rst_pin, irq_pin, t0_pin, osc_pin, ca, cb, sdo;
	logic [7:0] dir, latch, pin, p_out, p_oe, pu, die, pce;
	logic [2:0] pat;
	clk_src_t   src;
	usi_mode_t  universal_serial_unit;
	int         err_count, compares;
	logic [7:0] exp_osc [4] = '{8'h00, 8'h0f, 8'h0a, 8'h0f};
	port_b_alt_function_mux dut (.clock(clock), .reset_n(reset_n),
		.direction_reg(dir), .out_latch(latch), .pin_in(pin),
		.global_irq_enable(gie), .pin_change_irq_group_high(grp_hi),
		.pin_change_irq_group_low(grp_lo), .reset_pin_disable_fuse(fuse),
		.external_irq_zero(irq0), .ext_irq_low_level(low_lvl),
		.clock_select_bit2(cs2), .clock_select_bit1(cs1),
		.clock_source(src), .usi_mode(universal_serial_unit), .spi_prog_enable(spi),
		.usi_start_detect(start), .usi_data_out(sdo),
		.compare_a_output(ca), .compare_a_enable(ca_en),
		.compare_b_output(cb), .compare_b_enable(cb_en),
		.compare_b_inv_enable(cbi_en), .sleep_mode(sleep),
		.pad_out_ff(p_out), .pad_oe_ff(p_oe), .pull_up_ff(pu),
		.din_enable_ff(die), .pin_change_en_ff(pce),
		.ext_reset_n_ff(rst_pin), .ext_irq_zero_in_ff(irq_pin),
		.counter_zero_ext_clock_pin_ff(t0_pin),
		.osc_input_pin_ff(osc_pin));
	timer_serial_model partner (.clock(clock), .pattern(pat),
		.cmp_a_ff(ca), .cmp_b_ff(cb), .data_out_ff(sdo));
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic step;
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask : step
	task automatic end_sim;
		$display("mismatches %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// whole run is 24 steps; generous margin
	initial begin
		#20000;
		err_count++;
		end_sim();
	end
	initial begin
		{err_count, compares} = 0;
		reset_n = 1'b0;
		{gie, grp_hi, grp_lo, fuse, irq0, low_lvl, cs2, cs1} = 8'he0;
		{spi, start, ca_en, cb_en, cbi_en, sleep} = 6'h00;
		{dir, latch, pin} = 24'h00_0000;
		pat = 3'h0;
		src = CLK_RC;
		universal_serial_unit = USI_OFF;
		repeat (12) @(posedge clock);
		@(negedge clock);
		chk("oe in reset", p_oe, 8'h00);
		chk("rst in reset", {7'h00, rst_pin}, 8'h01);
		reset_n = 1'b1;
		step();
		chk("pce awake", pce, 8'hfe);
		chk("din awake", die, 8'hfe);
		{sleep, dir} = 9'h1fe;
		step();
		chk("pce outputs", pce, 8'hfe);
		chk("din sleep", die, 8'hfe);
		gie = 1'b0;
		step();
		chk("pce no global", pce, 8'h00);
		{gie, grp_lo} = 2'h2;
		step();
		chk("pce high group", pce, 8'hf0);
		{grp_lo, fuse, pin} = 10'h3_80;
		step();
		chk("pce reset pin", pce, 8'h7e);
		chk("reset pin pads", {pu[7], p_oe[7], die[7]}, 8'h04);
		chk("reset level hi", {7'h00, rst_pin}, 8'h01);
		pin = 8'h00;
		step();
		chk("reset level lo", {7'h00, rst_pin}, 8'h00);
		{fuse, irq0, low_lvl, pin} = 11'h3_40;
		step();
		chk("pce level irq", pce, 8'hbe);
		chk("irq zero in", {7'h00, irq_pin}, 8'h01);
		{irq0, low_lvl, cs2, cs1} = 4'h3;
		step();
		chk("pce count clk", pce, 8'hbe);
		chk("count clk in", {7'h00, t0_pin}, 8'h01);
		{cs1, pin} = 9'h010;
		step();
		chk("pce one select", pce, 8'hfe);
		chk("count clk off", {7'h00, t0_pin}, 8'h00);
		chk("irq zero off", {7'h00, irq_pin}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			src = clk_src_t'(i);
			step();
			chk("osc pins", {4'h0, pce[5:4], p_oe[5:4]}, exp_osc[i]);
			chk("osc in", {7'h00, osc_pin}, {7'h00, ~i[0]});
		end
		{cb_en, pat} = 4'ha;
		step();
		chk("cmp b", {pce[3], p_oe[3], p_out[3]}, 8'h03);
		dir = 8'hf6;
		step();
		chk("cmp b input", {7'h00, p_oe[3]}, 8'h00);
		{cb_en, cbi_en, dir} = 10'h1_fe;
		step();
		chk("inv cmp b", {pce[2], p_oe[2], p_out[2]}, 8'h02);
		universal_serial_unit = USI_THREE;
		step();
		chk("sclk master", {pce[2], p_oe[2]}, 8'h01);
		spi = 1'b1;
		step();
		chk("sclk spi", {7'h00, p_oe[2]}, 8'h00);
		{spi, cbi_en, universal_serial_unit} = {2'h0, USI_TWO};
		step();
		chk("scl low", {p_oe[2], p_out[2], pu[2]}, 8'h04);
		latch = 8'h04;
		step();
		chk("scl free", {p_oe[2], pu[2]}, 8'h00);
		start = 1'b1;
		step();
		chk("scl start", {p_oe[2], pu[2]}, 8'h02);
		{start, pat, universal_serial_unit} = {4'h1, USI_THREE};
		step();
		chk("data out", {pce[1], p_oe[1], p_out[1]}, 8'h03);
		{dir, latch} = 16'h00_02;
		step();
		chk("data pull", {pu[1], p_oe[1]}, 8'h02);
		{ca_en, pat, universal_serial_unit, dir} = {4'hc, USI_OFF, 8'hfe};
		step();
		chk("cmp a", {pce[1], p_oe[1], p_out[1]}, 8'h03);
		end_sim();
	end
endmodule : test_port_b_alt_function_mux
`default_nettype wire

// ### sim/timer_serial_model.sv
// Purpose: far-side model of the timer compare and serial data outputs
// Assumes: the bench picks the pattern that these outputs carry
// Notes: values move just after the rising edge, like on-chip logic
`timescale 1ns/1ns
`default_nettype none
module timer_serial_model (
	input  wire logic       clock,
	input  wire logic [2:0] pattern,
	output logic            cmp_a_ff,
	output logic            cmp_b_ff,
	output logic            data_out_ff
);
	always_ff @(posedge clock) begin
		{cmp_a_ff, cmp_b_ff, data_out_ff} <= pattern;
	end
endmodule : timer_serial_model
`default_nettype wire
